// *** hdl/pqs_ctrl_if.sv ***
// Control bus between the host end and the sequencer device end
`timescale 1ns/10ps
interface pqs_ctrl_if;
  logic [7:0] addr;
  logic [15:0] wrData;
  logic wrStrobe;
  logic rdStrobe;
  logic [15:0] rdData;
  modport host (output addr, output wrData, output wrStrobe, output rdStrobe, input rdData);
  modport device (input addr, input wrData, input wrStrobe, input rdStrobe, output rdData);
endinterface

// *** hdl/pqs_device.sv ***
// Sequencer device end: register bank gated by power-on reset, write sequencer
//
// How it works
// - Supply low holds all logic in reset
// - Writes during power-on reset are dropped
// - Release leaves defaults, writes then accepted
// - Reset lasts at least 9.5 us
// - 0100h at 6Ch enables, edit index zero
// - Launch register starts at low-byte index
// - 0119h launches shutdown at index 25
// - Running flag high for whole sequence
// - Default start-up takes about 300 ms
// - Default shutdown takes about 330 ms
// - Start-up configures 48 kHz playback outputs
// - Host: enable, launch at 0, unmute
// - Offset corrections kept while powered
// - Power loss or soft reset restores defaults
// - 0111h selects entry 17 for editing
// - 6Dh and 6Eh edit the selected entry
// - Dummy calibration gives start-up under 50 ms
// - Host: master clock running before start-up
// - Host: shutdown only after default start-up (host code also accepts it after fast start-up)
// - Host: gate clock only after idle
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module pqs_device import pqs_pkg::*; #(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF,
  parameter int DEPTH = SEQ_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  pqs_ctrl_if.device ctrl,
  input wire logic analogSupplyOk,
  input wire logic coreSupplyOk,
  output logic porActive,
  output logic seqRunning,
  output logic offsetsHeld,
  output logic regWrStrobe,
  output logic [7:0] regWrAddr,
  output logic [15:0] regWrData,
  output logic [15:0] regWrMask
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_STEP = 3'b010,
    S_WAIT = 3'b100
  } pqs_seq_state_t;

  typedef struct packed {
    pqs_seq_state_t state;
    logic seqEnable;
    logic [7:0] editIndex;
    logic [15:0] launchWord;
    logic [7:0] stepIndex;
    logic [31:0] waitCount;
    logic lastStep;
    logic offsetsHeld;
    logic [15:0] rdData;
    logic wrStrobe;
    logic [7:0] wrAddr;
    logic [15:0] wrData;
    logic [15:0] wrMask;
  } pqs_dev_t;

  localparam pqs_dev_t DEV_RESET = '{state: S_IDLE, default: '0};

  pqs_dev_t s, next_s;
  logic [31:0] entries [DEPTH];
  logic coreReset;
  logic writeOk;
  logic softReset;
  logic [31:0] cur;
  logic [31:0] editEntry;
  logic [3:0] fieldBits;

  // ****************************************
  // Default sequence contents
  // ****************************************
  // Each entry is {target word, payload word}; steps not modelled are dummies
  function automatic logic [31:0] defaultEntry(input int idx);
    logic [15:0] tgt;
    logic [15:0] pay;
    tgt = DUMMY_TARGET_WORD;
    pay = ZERO_WORD;
    case (idx)
      17: begin
        // Offset calibration: 4-bit write, long settle
        tgt = {4'h3, 4'h0, REG_DCS_CTRL};
        pay = {8'h09, 8'h0f};
      end
      22: pay[LAST_BIT] = 1'b1;
      36: pay = {8'h09, 8'h00};
      37: pay = {8'h06, 8'h00};
      39: pay[LAST_BIT] = 1'b1;
      default: pay = ZERO_WORD;
    endcase
    return {tgt, pay};
  endfunction

  pqs_por_hold u_por (
    .clock(clock),
    .reset_n(reset_n),
    .analogSupplyOk(analogSupplyOk),
    .coreSupplyOk(coreSupplyOk),
    .porActive(porActive)
  );

  assign coreReset = !reset_n || porActive;
  assign writeOk = ctrl.wrStrobe && !porActive;
  assign softReset = writeOk && (ctrl.addr == REG_SW_RESET);
  assign editEntry = entries[s.editIndex[5:0]];
  assign cur = entries[s.stepIndex[5:0]];
  assign fieldBits = {1'b0, cur[WIDTH_LSB+16 +: 3]} + 4'h1;

  // ****************************************
  // Register file and sequencer
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.wrStrobe = 1'b0;
    next_s.rdData = ZERO_WORD;
    if (ctrl.rdStrobe && !porActive) begin
      if (ctrl.addr == REG_SW_RESET) begin
        next_s.rdData = DEVICE_ID;
      end else if (ctrl.addr == REG_SEQ_CTRL) begin
        next_s.rdData = {7'h00, s.seqEnable, s.editIndex};
      end else if (ctrl.addr == REG_SEQ_TARGET) begin
        next_s.rdData = editEntry[31:16];
      end else if (ctrl.addr == REG_SEQ_PAYLOAD) begin
        next_s.rdData = editEntry[15:0];
      end else if (ctrl.addr == REG_SEQ_LAUNCH) begin
        next_s.rdData = s.launchWord;
      end else if (ctrl.addr == REG_SEQ_STATUS) begin
        next_s.rdData = {15'h0000, (s.state != S_IDLE)};
      end
    end
    case (s.state)
      S_STEP: begin
        // a dummy target issues nothing but still waits
        if (cur[23:16] != DUMMY_TARGET) begin
          next_s.wrStrobe = 1'b1;
          next_s.wrAddr = cur[23:16];
          next_s.wrMask = 16'(((17'h00001 << fieldBits) - 17'h00001)
                              << cur[FIELD_LSB_LSB+16 +: 4]);
          next_s.wrData = 16'({8'h00, cur[7:0]} << cur[FIELD_LSB_LSB+16 +: 4]);
          if (cur[23:16] == REG_DCS_CTRL && cur[7:0] != 8'h00) begin
            next_s.offsetsHeld = 1'b1;
          end
        end
        next_s.waitCount = 32'(STEP_CYCLES) << cur[WAIT_LSB +: 4];
        next_s.lastStep = cur[LAST_BIT] || (s.stepIndex == 8'(DEPTH - 1));
        next_s.state = S_WAIT;
      end
      S_WAIT: begin
        if (s.waitCount > 32'h00000001) begin
          next_s.waitCount = s.waitCount - 32'h00000001;
        end else if (s.lastStep) begin
          next_s.state = S_IDLE;
        end else begin
          next_s.stepIndex = s.stepIndex + 8'h01;
          next_s.state = S_STEP;
        end
      end
      default: next_s.state = S_IDLE;
    endcase
    if (writeOk) begin
      if (ctrl.addr == REG_SEQ_CTRL) begin
        next_s.seqEnable = ctrl.wrData[SEQ_ENABLE_BIT];
        next_s.editIndex = ctrl.wrData[7:0];
        if (!ctrl.wrData[SEQ_ENABLE_BIT]) begin
          next_s.state = S_IDLE;
        end
      end else if (ctrl.addr == REG_SEQ_LAUNCH) begin
        next_s.launchWord = ctrl.wrData;
        if (ctrl.wrData[ABORT_BIT]) begin
          next_s.state = S_IDLE;
        end else if (ctrl.wrData[LAUNCH_BIT] && s.seqEnable
                     && ctrl.wrData[7:0] < 8'(DEPTH)) begin
          next_s.stepIndex = ctrl.wrData[7:0];
          next_s.state = S_STEP;
        end
      end
    end
    if (softReset) begin
      next_s = DEV_RESET;
    end
  end

  always_ff @(posedge clock) begin
    if (coreReset) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Entry store: restored whole on power-on or soft reset
  always_ff @(posedge clock) begin
    if (coreReset || softReset) begin
      for (int i = 0; i < DEPTH; i++) begin
        entries[i] <= defaultEntry(i);
      end
    end else if (writeOk && ctrl.addr == REG_SEQ_TARGET) begin
      entries[s.editIndex[5:0]][31:16] <= ctrl.wrData;
    end else if (writeOk && ctrl.addr == REG_SEQ_PAYLOAD) begin
      entries[s.editIndex[5:0]][15:0] <= ctrl.wrData;
    end
  end

  assign ctrl.rdData = s.rdData;
  assign seqRunning = (s.state != S_IDLE);
  assign offsetsHeld = s.offsetsHeld;
  assign regWrStrobe = s.wrStrobe;
  assign regWrAddr = s.wrAddr;
  assign regWrData = s.wrData;
  assign regWrMask = s.wrMask;
endmodule // pqs_device

// *** hdl/pqs_host.sv ***
// Host end: runs the quick start-up, fast start-up and shutdown scripts
`timescale 1ns/10ps
module pqs_host import pqs_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  pqs_ctrl_if.host ctrl,
  input wire logic [7:0] cmdAddr,
  input wire logic [15:0] cmdWrData,
  input wire logic cmdWr,
  input wire logic cmdRd,
  output logic [15:0] cmdRdData,
  output logic masterClockRun
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_ISSUE = 4'b0010,
    H_POLL = 4'b0100,
    H_CHECK = 4'b1000
  } pqs_host_state_t;

  typedef struct packed {
    pqs_host_state_t state;
    logic [1:0] op;
    logic [2:0] step;
    logic started;
    logic clockRun;
    logic refused;
    logic [7:0] addr;
    logic [15:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [15:0] cmdRdData;
  } pqs_host_reg_t;

  pqs_host_reg_t s, next_s;
  logic [25:0] item;

  // Script item: {kind, address, data}
  function automatic logic [25:0] script(input logic [1:0] op, input logic [2:0] step);
    logic [25:0] r;
    r = {K_END, 8'h00, ZERO_WORD};
    case (op)
      OP_STARTUP: begin
        case (step)
          3'd0: r = {K_WRITE, REG_SEQ_CTRL, SEQ_ENABLE_IDX0};
          3'd1: r = {K_WRITE, REG_SEQ_LAUNCH, LAUNCH_STARTUP};
          3'd2: r = {K_WRITE, REG_DAC_CTRL, ZERO_WORD};
          3'd3: r = {K_POLL, REG_SEQ_STATUS, ZERO_WORD};
          default: r = {K_END, 8'h00, ZERO_WORD};
        endcase
      end
      OP_FAST: begin
        case (step)
          3'd0: r = {K_WRITE, REG_SEQ_CTRL, SEQ_ENABLE_IDX17};
          3'd1: r = {K_WRITE, REG_SEQ_TARGET, DUMMY_TARGET_WORD};
          3'd2: r = {K_WRITE, REG_SEQ_PAYLOAD, ZERO_WORD};
          3'd3: r = {K_WRITE, REG_SEQ_LAUNCH, LAUNCH_STARTUP};
          3'd4: r = {K_WRITE, REG_DAC_CTRL, ZERO_WORD};
          3'd5: r = {K_POLL, REG_SEQ_STATUS, ZERO_WORD};
          default: r = {K_END, 8'h00, ZERO_WORD};
        endcase
      end
      OP_SHUTDOWN: begin
        case (step)
          3'd0: r = {K_WRITE, REG_SEQ_LAUNCH, LAUNCH_SHUTDOWN};
          3'd1: r = {K_POLL, REG_SEQ_STATUS, ZERO_WORD};
          // Clears the system clock gate; the whole register is written zero
          3'd2: r = {K_WRITE, REG_CLOCK_CTRL, ZERO_WORD};
          default: r = {K_END, 8'h00, ZERO_WORD};
        endcase
      end
      default: r = {K_END, 8'h00, ZERO_WORD};
    endcase
    return r;
  endfunction

  assign item = script(s.op, s.step);

  always_comb begin
    next_s = s;
    next_s.wrStrobe = 1'b0;
    next_s.rdStrobe = 1'b0;
    next_s.cmdRdData = ZERO_WORD;
    if (cmdRd) begin
      if (cmdAddr == HREG_STATUS) begin
        next_s.cmdRdData = {12'h000, s.refused, s.clockRun, s.started, (s.state != H_IDLE)};
      end else if (cmdAddr == HREG_COMMAND) begin
        next_s.cmdRdData = {14'h0000, s.op};
      end
    end
    case (s.state)
      H_IDLE: begin
        if (cmdWr && cmdAddr == HREG_COMMAND && cmdWrData[1:0] != 2'h0) begin
          // Shutdown only from the started state, start-up only from stopped
          if ((cmdWrData[1:0] == OP_SHUTDOWN) != s.started) begin
            next_s.refused = 1'b1;
          end else begin
            next_s.refused = 1'b0;
            next_s.op = cmdWrData[1:0];
            next_s.step = 3'd0;
            next_s.clockRun = 1'b1;
            next_s.state = H_ISSUE;
          end
        end
      end
      H_ISSUE: begin
        next_s.addr = item[23:16];
        next_s.wrData = item[15:0];
        if (item[25:24] == K_WRITE) begin
          next_s.wrStrobe = 1'b1;
          next_s.step = s.step + 3'd1;
        end else if (item[25:24] == K_POLL) begin
          next_s.rdStrobe = 1'b1;
          next_s.state = H_POLL;
        end else begin
          next_s.started = (s.op != OP_SHUTDOWN);
          next_s.clockRun = (s.op != OP_SHUTDOWN);
          next_s.state = H_IDLE;
        end
      end
      H_POLL: next_s.state = H_CHECK;
      H_CHECK: begin
        if (ctrl.rdData[0]) begin
          next_s.rdStrobe = 1'b1;
          next_s.state = H_POLL;
        end else begin
          next_s.step = s.step + 3'd1;
          next_s.state = H_ISSUE;
        end
      end
      default: next_s.state = H_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s <= '{state: H_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign ctrl.addr = s.addr;
  assign ctrl.wrData = s.wrData;
  assign ctrl.wrStrobe = s.wrStrobe;
  assign ctrl.rdStrobe = s.rdStrobe;
  assign cmdRdData = s.cmdRdData;
  assign masterClockRun = s.clockRun;
endmodule // pqs_host

// *** hdl/pqs_pkg.sv ***
// Shared constants for the power-on reset and quick sequencer ends
package pqs_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PS = 8000;
  localparam int POR_MIN_PS = 9500000;
  localparam int POR_CYCLES = (POR_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int STEP_BASE_PS = 562500000;
  localparam int STEP_CYCLES_DEF = STEP_BASE_PS / CLK_PS;
  localparam int SEQ_DEPTH = 64;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_SW_RESET = 8'h00;
  localparam logic [7:0] REG_CLOCK_CTRL = 8'h16;
  localparam logic [7:0] REG_DAC_CTRL = 8'h21;
  localparam logic [7:0] REG_DCS_CTRL = 8'h43;
  localparam logic [7:0] REG_SEQ_CTRL = 8'h6c;
  localparam logic [7:0] REG_SEQ_TARGET = 8'h6d;
  localparam logic [7:0] REG_SEQ_PAYLOAD = 8'h6e;
  localparam logic [7:0] REG_SEQ_LAUNCH = 8'h6f;
  localparam logic [7:0] REG_SEQ_STATUS = 8'h70;
  localparam logic [7:0] DUMMY_TARGET = 8'hff;
  localparam logic [7:0] HREG_COMMAND = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h01;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SEQ_ENABLE_BIT = 8;
  localparam int LAUNCH_BIT = 8;
  localparam int ABORT_BIT = 9;
  localparam int LAST_BIT = 14;
  localparam int WIDTH_LSB = 12;
  localparam int FIELD_LSB_LSB = 8;
  localparam int WAIT_LSB = 8;
  // ****************************************
  // Command values
  // ****************************************
  localparam logic [15:0] SEQ_ENABLE_IDX0 = 16'h0100;
  localparam logic [15:0] SEQ_ENABLE_IDX17 = 16'h0111;
  localparam logic [15:0] LAUNCH_STARTUP = 16'h0100;
  localparam logic [15:0] LAUNCH_SHUTDOWN = 16'h0119;
  localparam logic [15:0] DUMMY_TARGET_WORD = 16'h00ff;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] DEVICE_ID = 16'h1234; // Arbitrary value
  localparam logic [1:0] OP_STARTUP = 2'h1;
  localparam logic [1:0] OP_SHUTDOWN = 2'h2;
  localparam logic [1:0] OP_FAST = 2'h3;
  // Host script step kinds
  localparam logic [1:0] K_WRITE = 2'h0;
  localparam logic [1:0] K_POLL = 2'h1;
  localparam logic [1:0] K_END = 2'h2;
endpackage

// *** hdl/pqs_por_hold.sv ***
// Power-on reset hold: supply monitors synchronised, minimum hold counted
`timescale 1ns/10ps
module pqs_por_hold import pqs_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic analogSupplyOk,
  input wire logic coreSupplyOk,
  output logic porActive
);
  typedef struct packed {
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [11:0] holdCount;
    logic active;
  } pqs_por_t;
  pqs_por_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.syncA = {s.syncA[0], analogSupplyOk};
    next_s.syncB = {s.syncB[0], coreSupplyOk};
    if (!(s.syncA[1] && s.syncB[1])) begin
      // Either supply low restarts the full hold
      next_s.holdCount = '0;
      next_s.active = 1'b1;
    end else if (s.holdCount < 12'(POR_CYCLES)) begin
      next_s.holdCount = s.holdCount + 12'h001;
    end else begin
      next_s.active = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s <= '{syncA: 2'h0, syncB: 2'h0, holdCount: 12'h000, active: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign porActive = s.active;
endmodule // pqs_por_hold

// *** test/pqs_monitor.sv ***
// Concurrent checks on the control bus and the sequencer status outputs
`timescale 1ns/10ps
module pqs_monitor import pqs_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [15:0] rdData,
  input wire logic porActive,
  input wire logic seqRunning,
  input wire logic regWrStrobe,
  input wire logic [7:0] regWrAddr
);
  // Shadow of the enable bit, so a launch is only expected when it was armed
  logic seqEn = 1'b0;
  logic [15:0] porCnt = 16'h0;
  always_ff @(posedge clock) begin
    if (porActive) begin
      seqEn <= 1'b0;
    end else if (wrStrobe && addr == REG_SEQ_CTRL) begin
      seqEn <= wrData[SEQ_ENABLE_BIT];
    end
    porCnt <= !porActive ? 16'h0 : (porCnt == 16'hffff ? porCnt : porCnt + 16'h1);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_launch;
    !porActive && seqEn && wrStrobe && addr == REG_SEQ_LAUNCH && wrData[LAUNCH_BIT]
      && !wrData[ABORT_BIT] && wrData[7:0] < 8'(SEQ_DEPTH);
  endsequence
  sequence s_run_min;
    seqRunning [*4];
  endsequence
  property p_one_strobe; !(wrStrobe && rdStrobe); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes high");
  property p_rd_idle; !$past(rdStrobe) |-> rdData == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  // State is cleared on the edge that first sees the reset, so quiet follows one cycle later
  property p_por_quiet; porActive |=> !seqRunning && !regWrStrobe; endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("activity in reset");
  property p_por_drop; porActive && wrStrobe |=> !seqRunning; endproperty
  a_por_drop: assert property (p_por_drop) else $error("write taken in reset");
  property p_launch; s_launch |=> s_run_min; endproperty
  a_launch: assert property (p_launch) else $error("launch did not run");
  property p_dummy; regWrStrobe |-> regWrAddr != DUMMY_TARGET; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy step wrote");
  property p_wr_in_run; regWrStrobe |-> seqRunning; endproperty
  a_wr_in_run: assert property (p_wr_in_run) else $error("write while idle");
  property p_por_min; $fell(porActive) |-> $past(porCnt) >= 16'(POR_CYCLES); endproperty
  a_por_min: assert property (p_por_min) else $error("reset too short");
endmodule // pqs_monitor

// *** test/test_power_on_reset_and_quick_sequence.sv ***
// Bench: host and device ends joined over the control bus, driven from the host port
`timescale 1ns/10ps
module test_power_on_reset_and_quick_sequence import pqs_pkg::*;;
  localparam int STEP = 4;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic analogSupplyOk = 1'b0;
  logic coreSupplyOk = 1'b0;
  logic [7:0] cmdAddr = 8'h0;
  logic [15:0] cmdWrData = 16'h0;
  logic cmdWr = 1'b0;
  logic cmdRd = 1'b0;
  logic [15:0] cmdRdData, regWrData, regWrMask, rd;
  logic [15:0] rnd = 16'h7dba;
  logic masterClockRun, porActive, seqRunning, offsetsHeld, regWrStrobe;
  logic [7:0] regWrAddr;
  logic [15:0] calData, calMask;
  int error_cnt = 0;
  int cmp_count = 0;
  int runCnt, calCnt, n, e;
  logic [23:0] wlog[$];
  logic [23:0] upLog[3] = '{{REG_SEQ_CTRL, SEQ_ENABLE_IDX0}, {REG_SEQ_LAUNCH, LAUNCH_STARTUP},
    {REG_DAC_CTRL, ZERO_WORD}};
  logic [23:0] fastLog[5] = '{{REG_SEQ_CTRL, SEQ_ENABLE_IDX17}, {REG_SEQ_TARGET, DUMMY_TARGET_WORD},
    {REG_SEQ_PAYLOAD, ZERO_WORD}, {REG_SEQ_LAUNCH, LAUNCH_STARTUP}, {REG_DAC_CTRL, ZERO_WORD}};
  pqs_ctrl_if bus();
  pqs_host u_pqs_host (.clock(clock), .reset_n(reset_n), .ctrl(bus), .cmdAddr(cmdAddr),
    .cmdWrData(cmdWrData), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdData(cmdRdData),
    .masterClockRun(masterClockRun));
  pqs_device #(.STEP_CYCLES(STEP), .DEPTH(SEQ_DEPTH)) u_pqs_device (.clock(clock),
    .reset_n(reset_n), .ctrl(bus), .analogSupplyOk(analogSupplyOk), .coreSupplyOk(coreSupplyOk),
    .porActive(porActive), .seqRunning(seqRunning), .offsetsHeld(offsetsHeld),
    .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .regWrMask(regWrMask));
  pqs_monitor u_pqs_monitor (.clock(clock), .reset_n(reset_n), .addr(bus.addr),
    .wrData(bus.wrData), .wrStrobe(bus.wrStrobe), .rdStrobe(bus.rdStrobe), .rdData(bus.rdData),
    .porActive(porActive), .seqRunning(seqRunning), .regWrStrobe(regWrStrobe),
    .regWrAddr(regWrAddr));
  always #4 clock = ~clock;
  // Sampled mid-cycle so flop updates at the edge never race the log
  always @(negedge clock) begin
    if (seqRunning === 1'b1) runCnt++;
    if (regWrStrobe === 1'b1 && regWrAddr === REG_DCS_CTRL) begin
      calCnt++;
      calData = regWrData;
      calMask = regWrMask;
    end
    if (bus.wrStrobe === 1'b1) wlog.push_back({bus.addr, bus.wrData});
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [23:0] b(input logic v);
    return {23'h0, v};
  endfunction
  // Nominal run length of the stored entries from a launch index
  function automatic int seq_cycles(input int first, input bit fast);
    int w;
    seq_cycles = 0;
    for (int i = first; i < SEQ_DEPTH; i++) begin
      w = ((i == 17 && !fast) || i == 36) ? 9 : (i == 37 ? 6 : 0);
      seq_cycles += STEP << w;
      if (i == 22 || i == 39) break;
    end
  endfunction
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_up(input string what);
    error_cnt++;
    $display("MISMATCH %s expected done seen timeout", what);
    summarize();
  endtask
  task automatic cmd_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    cmdAddr <= a;
    cmdWrData <= d;
    cmdWr <= 1'b1;
    @(posedge clock);
    cmdWr <= 1'b0;
  endtask
  task automatic cmd_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    cmdAddr <= a;
    cmdRd <= 1'b1;
    @(posedge clock);
    cmdRd <= 1'b0;
    @(negedge clock);
    d = cmdRdData;
  endtask
  task automatic gap();
    rnd = lfsr(rnd);
    @(posedge clock);
    cmdWrData <= rnd;
    repeat (rnd[3:0] + 1) @(posedge clock);
  endtask
  task automatic host_idle();
    n = 0;
    do begin
      cmd_rd(HREG_STATUS, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 4000);
    if (n >= 4000) give_up("host idle");
  endtask
  task automatic por_wait();
    n = 0;
    while (porActive !== 1'b0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) give_up("reset release");
  endtask
  task automatic run_op(input logic [1:0] op);
    gap();
    wlog.delete();
    runCnt = 0;
    calCnt = 0;
    cmd_wr(HREG_COMMAND, {14'h0, op});
    host_idle();
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    check("por held", b(porActive), b(1'b1));
    run_op(OP_STARTUP);
    check("run in reset", b(runCnt != 0), b(1'b0));
    @(posedge clock);
    analogSupplyOk <= 1'b1;
    coreSupplyOk <= 1'b1;
    por_wait();
    check("por length", b(n >= POR_CYCLES), b(1'b1));
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    por_wait();
    check("por again", b(n >= POR_CYCLES), b(1'b1));
    cmd_rd(HREG_STATUS, rd);
    check("status after reset", {20'h0, rd[3:0]}, 24'h0);
    $display("Test power-on reset done");
    run_op(OP_STARTUP);
    foreach (upLog[i]) check("start write", wlog[i], upLog[i]);
    e = seq_cycles(0, 1'b0);
    check("start time", b(runCnt >= e && runCnt <= e + 100), b(1'b1));
    check("offsets", b(offsetsHeld), b(1'b1));
    check("cal write", 24'(calCnt), 24'h1);
    check("cal data", {8'h00, calData}, 24'h00000f);
    check("cal mask", {8'h00, calMask}, 24'h00000f);
    check("clock run", b(masterClockRun), b(1'b1));
    cmd_wr(HREG_COMMAND, {14'h0, OP_STARTUP});
    cmd_rd(HREG_STATUS, rd);
    check("refused", {20'h0, rd[3:0]}, 24'he);
    $display("Test start-up done");
    run_op(OP_SHUTDOWN);
    check("stop write", wlog[0], {REG_SEQ_LAUNCH, LAUNCH_SHUTDOWN});
    check("gate last", wlog[wlog.size() - 1], {REG_CLOCK_CTRL, ZERO_WORD});
    check("clock stop", b(masterClockRun), b(1'b0));
    e = seq_cycles(25, 1'b0);
    check("stop time", b(runCnt >= e && runCnt <= e + 100), b(1'b1));
    check("offsets kept", b(offsetsHeld), b(1'b1));
    $display("Test shutdown done");
    run_op(OP_FAST);
    foreach (fastLog[i]) check("fast write", wlog[i], fastLog[i]);
    e = seq_cycles(0, 1'b1);
    check("fast time", b(runCnt >= e && runCnt <= e + 100), b(1'b1));
    check("fast cal", 24'(calCnt), 24'h0);
    $display("Test fast start-up done");
    @(posedge clock);
    coreSupplyOk <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check("por on loss", b(porActive), b(1'b1));
    // Device state clears on the edge after the reset is seen
    @(negedge clock);
    check("offsets lost", b(offsetsHeld), b(1'b0));
    @(posedge clock);
    coreSupplyOk <= 1'b1;
    por_wait();
    check("por after loss", b(n >= POR_CYCLES), b(1'b1));
    run_op(OP_SHUTDOWN);
    check("launch unarmed", b(runCnt != 0), b(1'b0));
    run_op(OP_STARTUP);
    check("cal restored", 24'(calCnt), 24'h1);
    check("offsets again", b(offsetsHeld), b(1'b1));
    $display("Test power loss done");
    summarize();
  end
endmodule // test_power_on_reset_and_quick_sequence
